// file: hw/iee_seq.sv
// Interrupt entry and exit sequencer of the 8-bit core
// How it works
// - Events set read-only sticky source flags
// - Request needs the local enable at one
// - Maskable entry only while global mask clear
// - Global mask comes up set after reset
// - Entry starts only at instruction boundary
// - Interrupt entry reuses software trap sequence
// - Set global mask after stacking registers
// - Fetch vector of highest pending source
// - Fill queue with three bytes from vector
// - Stack program counter low first, condition last
// - Stack pointer ends one below condition byte
// - Stacked counter is next instruction address
// - Return pops registers in reverse order
// - Return refills queue with three bytes
// - Index high byte never stacked or restored
// - Highest priority served first on unmask
// - New event after clear stays pending
// - Order: counter low, high, index low, accumulator, condition
// - Vector high byte first, low byte next
`include "iee_defs.svh"
module iee_seq
  import iee_pkg::*;
#(
  parameter int NSRC = `IEE_NSRC,
  parameter logic [15:0] VEC_BASE = `IEE_VEC_BASE,
  parameter logic [15:0] SWI_VEC = `IEE_SWI_VEC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Peripheral sources
  input wire logic [NSRC-1:0] srcEvent,
  input wire logic [NSRC-1:0] srcEnable,
  input wire logic [NSRC-1:0] srcFlagClr,
  output logic [NSRC-1:0] srcFlags,
  output logic irqPending,
  // Core instruction control
  input wire logic instrEnd,
  input wire logic swiReq,
  input wire logic rtiReq,
  input wire logic [15:0] nextPc,
  input wire logic [15:0] curSp,
  input wire logic [7:0] curA,
  input wire logic [7:0] curX,
  // Condition code register access from the core
  input wire logic ccrWe,
  input wire logic [7:0] ccrWdata,
  output logic [7:0] ccrOut,
  // Registers handed back to the core
  output logic [15:0] pcOut,
  output logic [15:0] spOut,
  output logic [7:0] aOut,
  output logic [7:0] xOut,
  output logic [7:0] queue0,
  output logic [7:0] queue1,
  output logic [7:0] queue2,
  output logic seqDone,
  output logic isRti,
  output logic busy,
  // Memory bus, read data one cycle after the read strobe
  output logic memRd,
  output logic memWr,
  output logic [15:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata
);

  localparam int IW = $clog2(NSRC);

  iee_src_if #(.NSRC(NSRC)) src (); // Flag unit carrier

  iee_state_t state_q; // Sequencer state
  iee_state_t state_d; // Next state
  logic [15:0] pc_q;   // Working program counter
  logic [15:0] sp_q;   // Working stack pointer
  logic [7:0] a_q;     // Working accumulator
  logic [7:0] x_q;     // Working index low
  logic [7:0] ccr_q;   // Condition code register
  logic [7:0] vecHi_q; // Fetched vector high byte
  logic [15:0] vec_q;  // Selected vector address
  logic swi_q;         // Current entry is a software trap
  logic rti_q;         // Current sequence is a return
  logic [1:0] fill_q;  // Fill byte counter
  logic [7:0] q0_q;    // Instruction queue byte 0
  logic [7:0] q1_q;    // Instruction queue byte 1
  logic [7:0] q2_q;    // Instruction queue byte 2
  logic done_q;        // Completion pulse
  logic startIrq;      // Maskable entry accepted
  logic startSwi;      // Software trap accepted
  logic startRti;      // Return accepted

  // Carrier hookup
  assign src.evt = srcEvent;
  assign src.en = srcEnable;
  assign src.clr = srcFlagClr;

  // Source flags and priority pick
  iee_src_flags #(.NSRC(NSRC)) u_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src(src)
  );

  // Sequence start decisions, only when the instruction ends
  always_comb begin
    startRti = 1'b0;
    startSwi = 1'b0;
    startIrq = 1'b0;
    if (state_q == SEQ_IDLE && instrEnd) begin
      if (rtiReq) begin
        startRti = 1'b1;
      end else if (swiReq) begin
        startSwi = 1'b1;
      end else if (src.pending && !ccr_q[`IEE_CCR_IBIT]) begin
        startIrq = 1'b1;
      end
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SEQ_IDLE: begin
        if (startRti) begin
          state_d = SEQ_POP_CCR;
        end else if (startSwi || startIrq) begin
          state_d = SEQ_PSH_PCL;
        end
      end
      // Push order fixed for trap and interrupt alike
      SEQ_PSH_PCL: state_d = SEQ_PSH_PCH;
      SEQ_PSH_PCH: state_d = SEQ_PSH_X;
      SEQ_PSH_X: state_d = SEQ_PSH_A;
      SEQ_PSH_A: state_d = SEQ_PSH_CCR;
      SEQ_PSH_CCR: state_d = SEQ_VEC_HI;
      SEQ_VEC_HI: state_d = SEQ_VEC_LO;
      SEQ_VEC_LO: state_d = SEQ_VEC_CAP;
      SEQ_VEC_CAP: state_d = SEQ_FILL;
      // Three queue reads, last byte captured afterwards
      SEQ_FILL: begin
        if (fill_q == `IEE_FILL_BYTES - 2'h1) begin
          state_d = SEQ_FILL_END;
        end
      end
      SEQ_FILL_END: state_d = SEQ_IDLE;
      // Pops in reverse of the push order
      SEQ_POP_CCR: state_d = SEQ_POP_A;
      SEQ_POP_A: state_d = SEQ_POP_X;
      SEQ_POP_X: state_d = SEQ_POP_PCH;
      SEQ_POP_PCH: state_d = SEQ_POP_PCL;
      SEQ_POP_PCL: state_d = SEQ_POP_END;
      SEQ_POP_END: state_d = SEQ_FILL;
      default: state_d = SEQ_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Sequence kind flags
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      swi_q <= 1'b0;
      rti_q <= 1'b0;
    end else if (state_q == SEQ_IDLE) begin
      swi_q <= startSwi;
      rti_q <= startRti;
    end
  end

  // Stack pointer: post-decrement on push, pre-increment on pop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sp_q <= 16'h0000;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          if (startRti || startSwi || startIrq) begin
            sp_q <= curSp;
          end
        end
        // Each push leaves the pointer on the next free byte
        SEQ_PSH_PCL, SEQ_PSH_PCH, SEQ_PSH_X, SEQ_PSH_A, SEQ_PSH_CCR: begin
          sp_q <= sp_q - 16'h0001;
        end
        SEQ_POP_CCR, SEQ_POP_A, SEQ_POP_X, SEQ_POP_PCH, SEQ_POP_PCL: begin
          sp_q <= sp_q + 16'h0001;
        end
        default: sp_q <= sp_q;
      endcase
    end
  end

  // Accumulator and index low, captured or popped; index high untouched
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      a_q <= 8'h00;
      x_q <= 8'h00;
    end else begin
      if (state_q == SEQ_IDLE && (startRti || startSwi || startIrq)) begin
        a_q <= curA;
        x_q <= curX;
      end
      if (state_q == SEQ_POP_X) begin
        a_q <= memRdata;
      end
      if (state_q == SEQ_POP_PCH) begin
        x_q <= memRdata;
      end
    end
  end

  // Program counter: next address on entry, vector or popped value later
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pc_q <= 16'h0000;
      vecHi_q <= 8'h00;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          if (startSwi || startIrq) begin
            pc_q <= nextPc;
          end
        end
        SEQ_VEC_LO: vecHi_q <= memRdata;
        SEQ_VEC_CAP: pc_q <= {vecHi_q, memRdata};
        SEQ_POP_PCL: vecHi_q <= memRdata;
        SEQ_POP_END: pc_q <= {vecHi_q, memRdata};
        default: pc_q <= pc_q;
      endcase
    end
  end

  // Vector chosen from the source pending while the condition byte is stacked
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vec_q <= VEC_BASE;
    end else if (state_q == SEQ_PSH_CCR) begin
      if (swi_q) begin
        vec_q <= SWI_VEC;
      end else begin
        vec_q <= VEC_BASE + {15'(src.topIdx), 1'b0};
      end
    end
  end

  // Condition code register: reset masked, set after stacking, popped on return
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ccr_q <= `IEE_CCR_RST;
    end else if (state_q == SEQ_PSH_CCR) begin
      ccr_q[`IEE_CCR_IBIT] <= 1'b1;
    end else if (state_q == SEQ_POP_A) begin
      ccr_q <= memRdata;
    end else if (state_q == SEQ_IDLE && ccrWe) begin
      ccr_q <= ccrWdata;
    end
  end

  // Queue fill counter and captured program bytes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      fill_q <= 2'h0;
      q0_q <= 8'h00;
      q1_q <= 8'h00;
      q2_q <= 8'h00;
    end else begin
      if (state_q == SEQ_FILL) begin
        fill_q <= fill_q + 2'h1;
        if (fill_q == 2'h1) begin
          q0_q <= memRdata;
        end
        if (fill_q == 2'h2) begin
          q1_q <= memRdata;
        end
      end else begin
        fill_q <= 2'h0;
      end
      if (state_q == SEQ_FILL_END) begin
        q2_q <= memRdata;
      end
    end
  end

  // Completion pulse one cycle after the last queue byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == SEQ_FILL_END);
    end
  end

  // Memory bus drive, all from registered state
  always_comb begin
    memRd = 1'b0;
    memWr = 1'b0;
    memAddr = 16'h0000;
    memWdata = 8'h00;
    unique case (state_q)
      SEQ_PSH_PCL: begin
        memWr = 1'b1;
        memAddr = sp_q;
        memWdata = pc_q[7:0];
      end
      SEQ_PSH_PCH: begin
        memWr = 1'b1;
        memAddr = sp_q;
        memWdata = pc_q[15:8];
      end
      SEQ_PSH_X: begin
        memWr = 1'b1;
        memAddr = sp_q;
        memWdata = x_q;
      end
      SEQ_PSH_A: begin
        memWr = 1'b1;
        memAddr = sp_q;
        memWdata = a_q;
      end
      // Condition byte stacked before the mask is set
      SEQ_PSH_CCR: begin
        memWr = 1'b1;
        memAddr = sp_q;
        memWdata = ccr_q;
      end
      SEQ_VEC_HI: begin
        memRd = 1'b1;
        memAddr = vec_q;
      end
      SEQ_VEC_LO: begin
        memRd = 1'b1;
        memAddr = vec_q + 16'h0001;
      end
      SEQ_FILL: begin
        memRd = 1'b1;
        memAddr = pc_q + {14'h0000, fill_q};
      end
      SEQ_POP_CCR, SEQ_POP_A, SEQ_POP_X, SEQ_POP_PCH, SEQ_POP_PCL: begin
        memRd = 1'b1;
        memAddr = sp_q + 16'h0001;
      end
      default: begin
        memRd = 1'b0;
      end
    endcase
  end

  // Outputs to the core
  assign srcFlags = src.flags;
  assign irqPending = src.pending;
  assign ccrOut = ccr_q;
  assign pcOut = pc_q;
  assign spOut = sp_q;
  assign aOut = a_q;
  assign xOut = x_q;
  assign queue0 = q0_q;
  assign queue1 = q1_q;
  assign queue2 = q2_q;
  assign seqDone = done_q;
  assign isRti = rti_q;
  assign busy = (state_q != SEQ_IDLE);

endmodule

// file: hw/iee_defs.svh
// Constants for the interrupt entry and exit sequencer
`ifndef IEE_DEFS_SVH
`define IEE_DEFS_SVH

// Bit position of the global mask in the condition code register
`define IEE_CCR_IBIT 3
// Condition code register value after reset, mask set
`define IEE_CCR_RST 8'h08
// Vector address of the lowest-priority source
`define IEE_VEC_BASE 16'hFFB0
// Vector address used by the software trap instruction
`define IEE_SWI_VEC 16'hFFFC
// Program bytes read to fill the instruction queue
`define IEE_FILL_BYTES 2'h3
// Number of peripheral interrupt sources
`define IEE_NSRC 8

`endif

// file: hw/iee_pkg.sv
// Types and shared functions of the interrupt entry and exit sequencer
package iee_pkg;

  // Sequencer states
  typedef enum logic [4:0] {
    SEQ_IDLE    = 5'h00,
    SEQ_PSH_PCL = 5'h01,
    SEQ_PSH_PCH = 5'h02,
    SEQ_PSH_X   = 5'h03,
    SEQ_PSH_A   = 5'h04,
    SEQ_PSH_CCR = 5'h05,
    SEQ_VEC_HI  = 5'h06,
    SEQ_VEC_LO  = 5'h07,
    SEQ_VEC_CAP = 5'h08,
    SEQ_FILL    = 5'h09,
    SEQ_FILL_END = 5'h0A,
    SEQ_POP_CCR = 5'h0B,
    SEQ_POP_A   = 5'h0C,
    SEQ_POP_X   = 5'h0D,
    SEQ_POP_PCH = 5'h0E,
    SEQ_POP_PCL = 5'h0F,
    SEQ_POP_END = 5'h10
  } iee_state_t;

  // Index of the highest-priority active bit; higher index wins
  function automatic logic [7:0] iee_top_index(input logic [255:0] req, input int n);
    logic [7:0] idx;
    idx = 8'h00;
    for (int i = 0; i < n; i++) begin
      if (req[i]) begin
        idx = 8'(i);
      end
    end
    return idx;
  endfunction

endpackage

// file: hw/iee_src_if.sv
// Carrier between the source flag unit and the sequencer
interface iee_src_if #(
  parameter int NSRC = 8
);
  logic [NSRC-1:0] evt;      // Source event pulses
  logic [NSRC-1:0] en;       // Local interrupt enables
  logic [NSRC-1:0] clr;      // Software flag clear strobes
  logic [NSRC-1:0] flags;    // Sticky status flags
  logic pending;             // Any enabled flag set
  logic [$clog2(NSRC)-1:0] topIdx; // Highest-priority pending source

  modport unit (input evt, input en, input clr, output flags, output pending, output topIdx);
  modport seq (output evt, output en, output clr, input flags, input pending, input topIdx);
endinterface

// file: hw/iee_src_flags.sv
// Sticky source flags, local enable qualification and priority pick
module iee_src_flags
  import iee_pkg::*;
#(
  parameter int NSRC = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Source side
  iee_src_if.unit src
);

  logic [NSRC-1:0] flag_q; // Status flags
  logic [NSRC-1:0] req;    // Qualified requests
  logic [255:0] reqWide;   // Request zero-extended for the pick

  // Flags set on event, cleared only by software; set beats clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~src.clr) | src.evt;
    end
  end

  // Level request while flag and local enable both stand
  assign req = flag_q & src.en;
  assign reqWide = 256'(req);

  assign src.flags = flag_q;
  assign src.pending = |req;
  // Highest index is the highest priority
  assign src.topIdx = $clog2(NSRC)'(iee_top_index(reqWide, NSRC));

endmodule

// file: verification/iee_seq_asserts.sv
// Port checker of the interrupt entry and exit sequencer
module iee_seq_asserts
  import iee_pkg::*;
#(
  parameter int NSRC = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Sources
  input wire logic [NSRC-1:0] srcEvent,
  input wire logic [NSRC-1:0] srcEnable,
  input wire logic [NSRC-1:0] srcFlags,
  input wire logic irqPending,
  // Core side
  input wire logic instrEnd,
  input wire logic swiReq,
  input wire logic rtiReq,
  input wire logic [15:0] nextPc,
  input wire logic [15:0] curSp,
  input wire logic [7:0] curA,
  input wire logic [7:0] curX,
  input wire logic [7:0] ccrOut,
  input wire logic [15:0] spOut,
  input wire logic seqDone,
  input wire logic isRti,
  input wire logic busy,
  // Memory bus
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic go, goEnt, goRti; // Sequence starts
  assign go = !busy && instrEnd;
  assign goRti = go && rtiReq;
  assign goEnt = go && !rtiReq && (swiReq || (irqPending && !ccrOut[3]));
  logic [15:0] sp_q, pc_q; // Values seen at start
  logic [7:0] a_q, x_q, cc_q;
  // Capture core registers at each start
  always_ff @(posedge core_clk) begin
    if (go) begin
      sp_q <= curSp;
      pc_q <= nextPc;
      a_q <= curA;
      x_q <= curX;
      cc_q <= ccrOut;
    end
  end
  a_mask_reset: assert property (disable iff (1'b0) !rst_n |=> ccrOut == 8'h08 && !busy)
    else $error("mask not set after reset");
  a_flag_set: assert property (|srcEvent |=> (srcFlags & $past(srcEvent)) == $past(srcEvent))
    else $error("event did not set flag");
  a_req_level: assert property (irqPending == |(srcFlags & srcEnable))
    else $error("request level wrong");
  a_masked_ignore: assert property (go && !swiReq && !rtiReq && ccrOut[3] |=> !busy)
    else $error("masked request taken");
  a_wait_boundary: assert property (!busy && !instrEnd |=> !busy)
    else $error("entry without instruction end");
  a_push_order: assert property (goEnt |=> memWr && memAddr == sp_q && memWdata == pc_q[7:0]
    ##1 memWr && memAddr == sp_q - 16'h1 && memWdata == pc_q[15:8]
    ##1 memWr && memAddr == sp_q - 16'h2 && memWdata == x_q
    ##1 memWr && memAddr == sp_q - 16'h3 && memWdata == a_q
    ##1 memWr && memAddr == sp_q - 16'h4 && memWdata == cc_q)
    else $error("stacking order wrong");
  a_mask_entry: assert property (goEnt |-> ##6 ccrOut[3])
    else $error("mask not set on entry");
  a_vector_order: assert property (goEnt |-> ##6 memRd ##1 memRd && memAddr == $past(memAddr) + 16'h1)
    else $error("vector fetch wrong");
  a_entry_fill: assert property (goEnt |-> ##9 memRd [*3] ##1 !memRd ##1 seqDone && spOut == sp_q - 16'h5)
    else $error("entry fill wrong");
  a_rti_pops: assert property (goRti |=> memRd && memAddr == sp_q + 16'h1
    ##4 memRd && memAddr == sp_q + 16'h5 ##1 !memRd ##1 memRd [*3]
    ##2 seqDone && isRti && spOut == sp_q + 16'h5)
    else $error("return sequence wrong");
  c_entry: cover property (goEnt && !swiReq);
  c_trap: cover property (goEnt && swiReq);
  c_return: cover property (goRti);
endmodule

bind iee_seq iee_seq_asserts #(.NSRC(NSRC)) u_chk (.core_clk, .rst_n, .srcEvent, .srcEnable,
  .srcFlags, .irqPending, .instrEnd, .swiReq, .rtiReq, .nextPc, .curSp, .curA, .curX, .ccrOut,
  .spOut, .seqDone, .isRti, .busy, .memRd, .memWr, .memAddr, .memWdata);

// file: verification/iee_mem_model.sv
// Byte memory answering one cycle after each read strobe
module iee_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus from the sequencer
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535]; // Whole address space
  // Known fill pattern
  initial begin
    memRdata = 8'h00;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
  end
  // Data stands one cycle, then toggles so stale bytes never match
  always @(posedge core_clk) begin
    if (memWr) mem[memAddr] <= memWdata;
    if (memRd) memRdata <= mem[memAddr];
    else memRdata <= ~memRdata;
  end
endmodule

// file: verification/cpu_interrupt_entry_exit_tb.sv
// Testbench of the interrupt entry and exit sequencer
module cpu_interrupt_entry_exit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, instrEnd, swiReq, rtiReq, ccrWe, irqPending, seqDone, isRti, busy;
  logic [7:0] srcEvent, srcEnable, srcFlagClr, srcFlags, ccrWdata, ccrOut, curA, curX;
  logic [7:0] aOut, xOut, queue0, queue1, queue2, memWdata, memRdata;
  logic [15:0] nextPc, curSp, pcOut, spOut, memAddr;
  logic memRd, memWr;
  int err_total, check_count, cyc, top;
  integer seed;
  logic [7:0] expFlags, ev, en, cc, av, xv; // Expected state
  logic [15:0] sp, pc;
  iee_seq #(.NSRC(8)) DUT (.core_clk, .rst_n, .srcEvent, .srcEnable, .srcFlagClr, .srcFlags,
    .irqPending, .instrEnd, .swiReq, .rtiReq, .nextPc, .curSp, .curA, .curX, .ccrWe, .ccrWdata,
    .ccrOut, .pcOut, .spOut, .aOut, .xOut, .queue0, .queue1, .queue2, .seqDone, .isRti, .busy,
    .memRd, .memWr, .memAddr, .memWdata, .memRdata);
  iee_mem_model u_mem (.core_clk, .memRd, .memWr, .memAddr, .memWdata, .memRdata);
  // Memory fill pattern
  function automatic logic [7:0] patt(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  // Highest set source
  function automatic int hi_src(input logic [7:0] m);
    int k;
    k = 0;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) k = i;
    end
    return k;
  endfunction
  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Event and clear strobes, then let flags settle
  task automatic pulse(input logic [7:0] e, input logic [7:0] c);
    @(posedge core_clk);
    srcEvent <= e;
    srcFlagClr <= c;
    @(posedge core_clk);
    srcEvent <= 8'h00;
    srcFlagClr <= 8'h00;
    @(posedge core_clk);
    expFlags = (expFlags & ~c) | e;
  endtask
  // Core write of condition codes
  task automatic wcc(input logic [7:0] v);
    @(posedge core_clk);
    ccrWe <= 1'b1;
    ccrWdata <= v;
    @(posedge core_clk);
    ccrWe <= 1'b0;
  endtask
  // Instruction end, bounded wait for completion
  task automatic run(input logic s, input logic r);
    @(posedge core_clk);
    instrEnd <= 1'b1;
    swiReq <= s;
    rtiReq <= r;
    @(posedge core_clk);
    instrEnd <= 1'b0;
    for (int i = 0; i < 20 && seqDone !== 1'b1; i++) @(posedge core_clk);
    chk(seqDone === 1'b1, "no completion");
  endtask
  // Instruction end that must not start anything; busy looked at one cycle after the start edge
  task automatic idle_end();
    @(posedge core_clk);
    instrEnd <= 1'b1;
    swiReq <= 1'b0;
    rtiReq <= 1'b0;
    @(posedge core_clk);
    instrEnd <= 1'b0;
    @(posedge core_clk);
    chk(busy === 1'b0 && seqDone === 1'b0, "unwanted entry");
  endtask
  // Entry, service routine clear and new event, then return
  task automatic visit(input logic s, input logic [15:0] v, input logic [7:0] c);
    logic [15:0] h;
    h = {patt(v), patt(v + 16'h1)};
    nextPc <= pc;
    curSp <= sp;
    curA <= av;
    curX <= xv;
    run(s, 1'b0);
    chk(u_mem.mem[sp] === pc[7:0] && u_mem.mem[sp - 16'h1] === pc[15:8], "pc");
    chk(u_mem.mem[sp - 16'h2] === xv && u_mem.mem[sp - 16'h3] === av, "x a");
    chk(u_mem.mem[sp - 16'h4] === cc && spOut === sp - 16'h5, "ccr sp");
    chk(ccrOut[3] === 1'b1 && queue0 === patt(h), "mask vector");
    chk(queue1 === patt(h + 16'h1) && queue2 === patt(h + 16'h2), "fill");
    pulse(8'h00, c);
    pulse(c, 8'h00);
    chk(srcFlags === expFlags, "flags");
    curSp <= sp - 16'h5;
    run(1'b0, 1'b1);
    chk(pcOut === pc && aOut === av && xOut === xv, "pop");
    chk(ccrOut === cc && spOut === sp && isRti === 1'b1, "pop ccr");
    chk(queue0 === patt(pc) && queue2 === patt(pc + 16'h2), "refill");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, instrEnd, swiReq, rtiReq, ccrWe, srcEvent, srcEnable, srcFlagClr} = '0;
    {ccrWdata, curA, curX, nextPc, curSp, expFlags} = '0;
    seed = 32'hc1fcd8cd;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk(ccrOut === 8'h08 && busy === 1'b0 && srcFlags === 8'h00, "reset");
    pulse(8'h24, 8'h00);
    chk(srcFlags === 8'h24 && irqPending === 1'b0, "flag");
    wcc(8'h00);
    idle_end();
    srcEnable <= 8'h24;
    wcc(8'h08);
    idle_end();
    pulse(8'h00, 8'h24);
    $display("test gating done");
    for (int n = 0; n < 8; n++) begin
      en = $random(seed) | 8'h01;
      ev = $random(seed) & en | 8'h01;
      sp = 16'h0400 + 16'($random(seed) & 16'h03FF);
      pc = 16'h8000 | 16'($random(seed));
      av = 8'($random(seed));
      xv = 8'($random(seed));
      cc = 8'($random(seed)) & 8'hF7;
      srcEnable <= en;
      pulse(ev, 8'h00);
      wcc(cc);
      repeat (3) @(posedge core_clk);
      chk(busy === 1'b0 && irqPending === 1'b1, "boundary");
      top = hi_src(expFlags & en);
      visit(1'b0, 16'hFFB0 + 16'(2 * top), 8'(1 << top));
    end
    $display("test entries done");
    cc = 8'($random(seed)) | 8'h08;
    wcc(cc);
    visit(1'b1, 16'hFFFC, 8'h00);
    $display("test trap done");
    print_verdict();
  end
endmodule
